// *** rtl/pack_power_mode_control.v ***
/*
  power-mode supervisor of a pack gauge: flash write guard, undervoltage
  shutdown with hold timer, offset calibration and sleep with periodic wake.
  assumes measurements arrive with a one-cycle update strobe, all inputs are
  synchronous to i_clk, and the register bus is apb with 32-bit data.
*/
`timescale 1ns/1ps
`include "pack_power_mode_control_regs.vh"
module pack_power_mode_control #(
  parameter TICK_CYCLES = `PPM_CLK_HZ / 1000000 * `PPM_SECOND_US,
  parameter CAL_CYCLES = `PPM_CAL_CYCLES
) (
  // clock, reset, enable
  input wire i_clk,
  input wire i_srst,
  input wire i_ce,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output wire o_pslverr,
  // measurements, signed
  input wire i_meas_update,
  input wire signed [15:0] i_batt_mv,
  input wire signed [15:0] i_pack_mv,
  input wire signed [15:0] i_current_ma,
  input wire signed [15:0] i_temp_dc,
  input wire signed [15:0] i_trim_in,
  // management bus lines and wake
  input wire i_bus_clk,
  input wire i_bus_data,
  input wire i_wake,
  // flash write request
  input wire i_flash_wr_req,
  output wire o_flash_wr_en,
  // power mode outputs
  output reg o_shutdown,
  output reg o_asleep,
  output reg o_cal_busy,
  output reg o_charger,
  output reg [15:0] o_counter_offset_trim
);
  // states
  // binary codes; the default branch sends anything else back to run
  localparam ST_RUN = 3'd0;
  localparam ST_CAL = 3'd1;
  localparam ST_SLEEP = 3'd2;
  localparam ST_WAKE = 3'd3;
  localparam ST_SHUT = 3'd4;

  // configuration registers
  reg [1:0] ctrl; // sleep enable, factory shutdown request
  reg [15:0] flash_guard_mv;
  reg [15:0] cutoff_mv;
  reg [15:0] cutoff_hold_s;
  reg [15:0] charger_mv;
  reg [15:0] idle_ma;
  reg [15:0] cal_temp_lo;
  reg [15:0] cal_temp_hi;
  reg [15:0] bus_idle_s;
  reg [15:0] sample_s;

  // latched measurements
  reg signed [15:0] batt_mv;
  reg signed [15:0] pack_mv;
  reg signed [15:0] current_ma;
  reg signed [15:0] temp_dc;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] tick_div; // divides the clock into one-second ticks
  reg tick;
  reg [7:0] cal_cnt;
  reg sd_cond; // all three shutdown conditions, per update
  reg idle_cond; // calibration conditions, per update
  wire [15:0] hold_cnt;
  wire [15:0] bus_cnt;
  wire [15:0] sample_cnt;

  // apb: zero wait states, unmapped reads as zero and errors
  wire apb_acc = i_psel && i_penable;
  wire apb_wr = apb_acc && i_pwrite;
  reg addr_hit;
  reg [31:0] rd_word; // decoded read word, taken into o_prdata at setup
  assign o_pready = 1'b1;
  assign o_pslverr = apb_acc && !addr_hit;

  // one-second time base
  // the divider runs free, so the first second of any timer may be short
  always @(posedge i_clk) begin
    if (i_srst) begin
      tick_div <= 32'h00000000;
      tick <= 1'b0;
    end else if (i_ce) begin
      tick <= 1'b0;
      if (tick_div >= TICK_CYCLES - 1) begin
        tick_div <= 32'h00000000;
        tick <= 1'b1;
      end else begin
        tick_div <= tick_div + 32'h00000001;
      end
    end
  end

  // register writes; factory shutdown bit self-clears after one cycle
  always @(posedge i_clk) begin
    if (i_srst) begin
      ctrl <= 2'b00;
      flash_guard_mv <= `PPM_RST_FLASH_GUARD_MV;
      cutoff_mv <= `PPM_RST_CUTOFF_MV;
      cutoff_hold_s <= `PPM_RST_CUTOFF_HOLD_S;
      charger_mv <= `PPM_RST_CHARGER_MV;
      idle_ma <= `PPM_RST_IDLE_MA;
      cal_temp_lo <= `PPM_RST_CAL_TEMP_LO;
      cal_temp_hi <= `PPM_RST_CAL_TEMP_HI;
      bus_idle_s <= `PPM_RST_BUS_IDLE_S;
      sample_s <= `PPM_RST_SAMPLE_S;
    end else if (i_ce) begin
      ctrl[`PPM_CTRL_FACTORY_SD] <= 1'b0;
      if (apb_wr) begin
        case (i_paddr)
          `PPM_OFS_CTRL: ctrl <= i_pwdata[1:0];
          `PPM_OFS_FLASH_GUARD_MV: flash_guard_mv <= i_pwdata[15:0];
          `PPM_OFS_CUTOFF_MV: cutoff_mv <= i_pwdata[15:0];
          `PPM_OFS_CUTOFF_HOLD_S: cutoff_hold_s <= i_pwdata[15:0];
          `PPM_OFS_CHARGER_MV: charger_mv <= i_pwdata[15:0];
          `PPM_OFS_IDLE_MA: idle_ma <= i_pwdata[15:0];
          `PPM_OFS_CAL_TEMP_LO: cal_temp_lo <= i_pwdata[15:0];
          `PPM_OFS_CAL_TEMP_HI: cal_temp_hi <= i_pwdata[15:0];
          `PPM_OFS_BUS_IDLE_S: bus_idle_s <= i_pwdata[15:0];
          `PPM_OFS_SAMPLE_S: sample_s <= i_pwdata[15:0];
          default: ctrl <= ctrl; // read-only or unmapped
        endcase
      end
    end
  end

  // read mux, combinational decode of the word the bus will see
  always @* begin
    addr_hit = 1'b1;
    case (i_paddr)
      `PPM_OFS_CTRL: rd_word = {30'h0000000, ctrl};
      `PPM_OFS_FLASH_GUARD_MV: rd_word = {16'h0000, flash_guard_mv};
      `PPM_OFS_CUTOFF_MV: rd_word = {16'h0000, cutoff_mv};
      `PPM_OFS_CUTOFF_HOLD_S: rd_word = {16'h0000, cutoff_hold_s};
      `PPM_OFS_CHARGER_MV: rd_word = {16'h0000, charger_mv};
      `PPM_OFS_IDLE_MA: rd_word = {16'h0000, idle_ma};
      `PPM_OFS_CAL_TEMP_LO: rd_word = {16'h0000, cal_temp_lo};
      `PPM_OFS_CAL_TEMP_HI: rd_word = {16'h0000, cal_temp_hi};
      `PPM_OFS_BUS_IDLE_S: rd_word = {16'h0000, bus_idle_s};
      `PPM_OFS_SAMPLE_S: rd_word = {16'h0000, sample_s};
      `PPM_OFS_STATUS: rd_word = {26'h000000, o_cal_busy, (hold_cnt != 16'h0000) || sd_cond,
                                  o_asleep, o_shutdown, o_flash_wr_en, o_charger};
      `PPM_OFS_TRIM: rd_word = {16'h0000, o_counter_offset_trim};
      default: begin
        rd_word = 32'h00000000;
        addr_hit = 1'b0;
      end
    endcase
  end

  // read data is taken into a flop in the setup phase, so it stands
  // unchanged through the whole access phase with no wait state;
  // the price is that status bits are one cycle old when sampled
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_prdata <= 32'h00000000;
    end else if (i_ce && i_psel && !i_penable) begin
      o_prdata <= rd_word;
    end
  end

  // latch measurements and evaluate conditions on each update
  always @(posedge i_clk) begin
    if (i_srst) begin
      batt_mv <= 16'h0000;
      pack_mv <= 16'h0000;
      current_ma <= 16'h0000;
      temp_dc <= 16'h0000;
      o_charger <= 1'b0;
      sd_cond <= 1'b0;
      idle_cond <= 1'b0;
    end else if (i_ce && i_meas_update) begin
      batt_mv <= i_batt_mv;
      pack_mv <= i_pack_mv;
      current_ma <= i_current_ma;
      temp_dc <= i_temp_dc;
      o_charger <= i_pack_mv >= $signed(charger_mv);
      // low voltage, discharging, no charger
      sd_cond <= (i_batt_mv < $signed(cutoff_mv)) && (i_current_ma < 16'sh0000)
                 && (i_pack_mv < $signed(charger_mv));
      // current inside +/- band, temperature inside window
      idle_cond <= (i_current_ma < $signed(idle_ma)) && (i_current_ma > -$signed(idle_ma))
                   && (i_temp_dc > $signed(cal_temp_lo))
                   && (i_temp_dc < $signed(cal_temp_hi));
    end
  end

  // flash guard: charger detection bypasses the voltage check
  assign o_flash_wr_en = i_flash_wr_req
                         && (o_charger || batt_mv >= $signed(flash_guard_mv));

  // bus lines both low counts idle seconds; any activity restarts
  // the count saturates, so a bus parked low for hours still reads idle
  wire bus_low = !i_bus_clk && !i_bus_data;
  sec_timer #(.WIDTH(16)) u_bus_timer (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_clear(1'b0),
    .i_run(bus_low),
    .i_tick(tick),
    .o_count(bus_cnt)
  );
  wire bus_idle = bus_cnt > bus_idle_s;

  // hold timer runs only while all conditions hold, cleared while shut down
  // a charger clears it too, so unplugging always restarts the hold count from zero
  wire hold_clear = (state == ST_SHUT) || o_charger;
  sec_timer #(.WIDTH(16)) u_hold_timer (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_clear(hold_clear),
    .i_run(sd_cond),
    .i_tick(tick),
    .o_count(hold_cnt)
  );
  // expiry only counts if the conditions are true right now too
  wire hold_done = sd_cond && (hold_cnt >= cutoff_hold_s);

  // sample period counter while asleep
  sec_timer #(.WIDTH(16)) u_sample_timer (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_clear(state != ST_SLEEP),
    .i_run(1'b1),
    .i_tick(tick),
    .o_count(sample_cnt)
  );

  // shutdown request: undervoltage or factory command, refused with charger
  wire sd_req = (hold_done || ctrl[`PPM_CTRL_FACTORY_SD]) && !o_charger;
  wire cal_go = idle_cond && bus_idle;

  // next-state logic
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (sd_req) begin
          next_state = ST_SHUT;
        end else if (cal_go) begin
          next_state = ST_CAL;
        end
      end
      ST_CAL: begin
        // sleep only if enabled; otherwise stay awake after calibrating
        // cal_cnt is 8 bits wide, so CAL_CYCLES must stay at or below 256
        if (cal_cnt >= CAL_CYCLES - 1) begin
          if (ctrl[`PPM_CTRL_SLEEP_EN] && cal_go) begin
            next_state = ST_SLEEP;
          end else begin
            next_state = ST_RUN;
          end
        end
      end
      ST_SLEEP: begin
        if (sd_req) begin
          next_state = ST_SHUT;
        end else if (sample_cnt >= sample_s) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // wait for the fresh current sample, then decide
        // a shutdown request is seen again once back in run or sleep
        if (i_meas_update) begin
          if ((i_current_ma < $signed(idle_ma)) && (i_current_ma > -$signed(idle_ma))) begin
            next_state = ST_SLEEP;
          end else begin
            next_state = ST_RUN;
          end
        end
      end
      ST_SHUT: begin
        // the protector drops our supply; a wake input models its return
        if (i_wake) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  // state, calibration counter, outputs
  always @(posedge i_clk) begin
    if (i_srst) begin
      state <= ST_RUN;
      cal_cnt <= 8'h00;
      o_shutdown <= 1'b0;
      o_asleep <= 1'b0;
      o_cal_busy <= 1'b0;
      o_counter_offset_trim <= 16'h0000;
    end else if (i_ce) begin
      state <= next_state;
      o_shutdown <= next_state == ST_SHUT;
      o_asleep <= next_state == ST_SLEEP;
      o_cal_busy <= next_state == ST_CAL;
      if (state == ST_CAL) begin
        cal_cnt <= cal_cnt + 8'h01;
      end else begin
        cal_cnt <= 8'h00;
      end
      // the trim is captured at the end of calibration
      if (state == ST_CAL && cal_cnt >= CAL_CYCLES - 1) begin
        o_counter_offset_trim <= i_trim_in;
      end
    end
  end
endmodule // pack_power_mode_control

// *** rtl/pack_power_mode_control_regs.vh ***
/*
  register map, field positions, reset values and timing counts for the
  pack power-mode supervisor.
  assumes a 32-bit apb slave with one aligned word per register.
*/
`ifndef PACK_POWER_MODE_CONTROL_REGS_VH
`define PACK_POWER_MODE_CONTROL_REGS_VH

// byte offsets
`define PPM_OFS_CTRL 12'h000
`define PPM_OFS_FLASH_GUARD_MV 12'h004
`define PPM_OFS_CUTOFF_MV 12'h008
`define PPM_OFS_CUTOFF_HOLD_S 12'h00C
`define PPM_OFS_CHARGER_MV 12'h010
`define PPM_OFS_IDLE_MA 12'h014
`define PPM_OFS_CAL_TEMP_LO 12'h018
`define PPM_OFS_CAL_TEMP_HI 12'h01C
`define PPM_OFS_BUS_IDLE_S 12'h020
`define PPM_OFS_SAMPLE_S 12'h024
`define PPM_OFS_STATUS 12'h028
`define PPM_OFS_TRIM 12'h02C

// control bits
`define PPM_CTRL_SLEEP_EN 0
`define PPM_CTRL_FACTORY_SD 1

// status bits
`define PPM_ST_CHARGER 0
`define PPM_ST_FLASH_OK 1
`define PPM_ST_SHUTDOWN 2
`define PPM_ST_ASLEEP 3
`define PPM_ST_HOLD_RUN 4
`define PPM_ST_CAL_BUSY 5

// reset values
`define PPM_RST_FLASH_GUARD_MV 16'h1D4C
`define PPM_RST_CUTOFF_MV 16'h1770
`define PPM_RST_CUTOFF_HOLD_S 16'h000A
`define PPM_RST_CHARGER_MV 16'h0DAC
`define PPM_RST_IDLE_MA 16'h000A
`define PPM_RST_CAL_TEMP_LO 16'h0032
`define PPM_RST_CAL_TEMP_HI 16'h01C2
`define PPM_RST_BUS_IDLE_S 16'h0005
`define PPM_RST_SAMPLE_S 16'h0014

// timing
`define PPM_CLK_HZ 10000000
`define PPM_SECOND_US 1000000
`define PPM_CAL_CYCLES 16

`endif

// *** rtl/sec_timer.v ***
/*
  seconds counter: counts whole seconds while enabled, clears on restart.
  assumes i_tick is a one-cycle pulse once per second.
*/
`timescale 1ns/1ps
module sec_timer #(
  parameter WIDTH = 16
) (
  // clock and control
  input wire i_clk,
  input wire i_srst,
  input wire i_ce,
  input wire i_clear,
  input wire i_run,
  input wire i_tick,
  // count
  output reg [WIDTH-1:0] o_count
);
  // saturates rather than wraps, so a long wait never looks short
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_count <= {WIDTH{1'b0}};
    end else if (i_ce) begin
      if (i_clear || !i_run) begin
        o_count <= {WIDTH{1'b0}};
      end else if (i_tick && o_count != {WIDTH{1'b1}}) begin
        o_count <= o_count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // sec_timer

// *** verif/afe_model.sv ***
/* companion protector model: owns the gauge supply and the wake line.
   assumes the gauge shutdown output is a registered level. */
`timescale 1ns/1ps
module afe_model (
  input wire i_clk,
  input wire i_shutdown,
  input wire i_wake_req,
  output logic o_supply_on,
  output logic o_wake
);
  // rail fully off while the gauge is shut down
  assign o_supply_on = !i_shutdown;
  // wake only means something while the rail is off
  always @(posedge i_clk) o_wake <= i_shutdown && i_wake_req;
endmodule // afe_model

// *** verif/pack_power_mode_control_chk.sv ***
/* port checker for the pack power-mode supervisor.
   assumes one clock domain and the same tick and calibration counts as the design. */
`timescale 1ns/1ps
module pack_power_mode_control_chk #(
  parameter TICK_CYCLES = 10,
  parameter CAL_CYCLES = 16
) (
  input wire i_clk,
  input wire i_srst,
  input wire i_psel,
  input wire i_penable,
  input wire i_meas_update,
  input wire i_flash_wr_req,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_flash_wr_en,
  input wire o_shutdown,
  input wire o_cal_busy,
  input wire o_charger,
  input wire [15:0] o_counter_offset_trim
);
  // one tick of slack: the first second of the hold may be short
  localparam int HOLD_MIN = 9 * TICK_CYCLES;
  int since_wake; // cycles since the last wake, saturating
  int cal_len; // cycles spent calibrating
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // helper counters; starts saturated so a first shutdown is not judged
  always @(posedge i_clk) begin
    if (i_srst) since_wake <= 1000000;
    else if ($fell(o_shutdown)) since_wake <= 0;
    else if (since_wake < 1000000) since_wake <= since_wake + 1;
    cal_len <= o_cal_busy ? cal_len + 1 : 0;
  end
  sequence s_cal_done; $past(o_cal_busy) && !o_cal_busy; endsequence
  property p_flash_req; o_flash_wr_en |-> i_flash_wr_req; endproperty
  property p_flash_chg; i_flash_wr_req && o_charger |-> o_flash_wr_en; endproperty
  property p_sd_chg; $rose(o_shutdown) |-> !$past(o_charger); endproperty
  property p_sd_hold; $rose(o_shutdown) |-> since_wake >= HOLD_MIN; endproperty
  property p_cal_len; s_cal_done |-> cal_len == CAL_CYCLES; endproperty
  property p_trim; $changed(o_counter_offset_trim) |-> $past(o_cal_busy); endproperty
  property p_chg_upd; $changed(o_charger) |-> $past(i_meas_update); endproperty
  property p_ready; o_pready; endproperty
  property p_slverr; o_pslverr |-> i_psel && i_penable; endproperty
  a_flash_req: assert property (p_flash_req) else $error("flash enable without request");
  a_flash_chg: assert property (p_flash_chg) else $error("charger did not open flash");
  a_sd_chg: assert property (p_sd_chg) else $error("shutdown with charger present");
  a_sd_hold: assert property (p_sd_hold) else $error("shutdown too soon after wake");
  a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
  a_trim: assert property (p_trim) else $error("trim moved outside calibration");
  a_chg_upd: assert property (p_chg_upd) else $error("charger flag moved off update");
  a_ready: assert property (p_ready) else $error("pready low");
  a_slverr: assert property (p_slverr) else $error("slverr outside access");
endmodule // pack_power_mode_control_chk
bind pack_power_mode_control pack_power_mode_control_chk #(.TICK_CYCLES(TICK_CYCLES), .CAL_CYCLES(CAL_CYCLES)) i_chk (
  .i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable), .i_meas_update(i_meas_update),
  .i_flash_wr_req(i_flash_wr_req), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_flash_wr_en(o_flash_wr_en),
  .o_shutdown(o_shutdown), .o_cal_busy(o_cal_busy), .o_charger(o_charger),
  .o_counter_offset_trim(o_counter_offset_trim));

// *** verif/tb.sv ***
/* self-checking bench for the pack power-mode supervisor.
   assumes a one-second tick of 10 cycles and default thresholds. */
`timescale 1ns/1ps
module tb;
  logic i_clk = 0, i_srst = 1, psel = 0, pen = 0, pwr = 0, upd = 0, bclk = 1, bdat = 1, wreq = 0, freq = 0, err;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, q;
  logic signed [15:0] batt = 0, pack = 0, cur = 0, temp = 16'sh00C8;
  wire pready, pslverr, fen, sd, slp, cal, chg, sup, wake;
  wire [31:0] prd;
  wire [15:0] trim;
  int bad_count = 0, checks_done = 0, n;
  pack_power_mode_control #(.TICK_CYCLES(10)) i_pack_power_mode_control (
    .i_clk(i_clk), .i_srst(i_srst), .i_ce(1'b1), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(pa), .i_pwdata(pwd), .o_pready(pready), .o_prdata(prd), .o_pslverr(pslverr),
    .i_meas_update(upd), .i_batt_mv(batt), .i_pack_mv(pack), .i_current_ma(cur), .i_temp_dc(temp),
    .i_trim_in(16'h0123), .i_bus_clk(bclk), .i_bus_data(bdat), .i_wake(wake), .i_flash_wr_req(freq),
    .o_flash_wr_en(fen), .o_shutdown(sd), .o_asleep(slp), .o_cal_busy(cal), .o_charger(chg),
    .o_counter_offset_trim(trim));
  afe_model i_afe_model (.i_clk(i_clk), .i_shutdown(sd), .i_wake_req(wreq), .o_supply_on(sup), .o_wake(wake));
  initial forever #50 i_clk = ~i_clk;
  // measurement strobe every 20 cycles
  initial forever begin
    repeat (19) @(posedge i_clk);
    upd <= 1;
    @(posedge i_clk) upd <= 0;
  end
  function logic sig(input int s);
    return s == 0 ? sd : (s == 1 ? cal : slp);
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1; pwr <= wr; pa <= a; pwd <= d; pen <= 0;
    @(posedge i_clk) pen <= 1;
    // only the watchdog ends a wait for pready
    do @(posedge i_clk); while (pready !== 1'b1);
    q = prd; err = pslverr; psel <= 0; pen <= 0; pwr <= 0;
  endtask
  // bounded wait for a mode output
  task wt(input int s, input logic v, input int mx);
    n = 0;
    while (sig(s) !== v && n < mx) begin @(posedge i_clk); n++; end
  endtask
  task wake_up;
    wreq <= 1; wt(0, 0, 20); wreq <= 0;
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    final_report;
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_srst <= 0;
    apb(0, 12'h004, 0); chk("guard", 32'h00001D4C, q);
    apb(0, 12'h00C, 0); chk("hold", 32'h0000000A, q);
    apb(0, 12'h014, 0); chk("idle", 32'h0000000A, q);
    apb(0, 12'h010, 0); chk("chg_lvl", 32'h00000DAC, q);
    apb(0, 12'h030, 0); chk("slverr", 1, err);
    $display("test regs done");
    batt <= 7499; freq <= 1; repeat (25) @(posedge i_clk); chk("fen_low", 0, fen);
    batt <= 7500; repeat (25) @(posedge i_clk); chk("fen_ok", 1, fen);
    batt <= 7000; pack <= 3500; repeat (25) @(posedge i_clk); chk("chg", 1, chg);
    chk("fen_chg", 1, fen);
    apb(1, 12'h000, 2); repeat (30) @(posedge i_clk); chk("sd_refused", 0, sd);
    pack <= 3499; repeat (25) @(posedge i_clk); chk("chg_off", 0, chg);
    apb(1, 12'h000, 2); wt(0, 1, 10); chk("sd_factory", 1, sd);
    chk("supply", 0, sup);
    wake_up; chk("woke", 0, sd);
    $display("test flash and factory done");
    batt <= 5999; cur <= -1; pack <= 0; repeat (70) @(posedge i_clk);
    cur <= 0; repeat (40) @(posedge i_clk);
    cur <= -1; repeat (80) @(posedge i_clk); chk("sd_cancel", 0, sd);
    wt(0, 1, 150); chk("sd_cut", 1, sd);
    wake_up; repeat (60) @(posedge i_clk); chk("sd_rearm", 0, sd);
    wt(0, 1, 150); chk("sd_again", 1, sd);
    wake_up;
    $display("test cutoff done");
    batt <= 8000; cur <= 5; bclk <= 0; bdat <= 0;
    wt(1, 1, 200); chk("cal", 1, cal);
    wt(1, 0, 40); chk("trim", 32'h00000123, trim);
    chk("no_sleep", 0, slp);
    apb(1, 12'h000, 1); wt(2, 1, 300); chk("asleep", 1, slp);
    wt(2, 0, 300); n = 0;
    repeat (25) begin @(posedge i_clk); if (cal === 1'b1) n++; end
    chk("resleep", 1, slp);
    chk("no_recal", 0, n);
    cur <= 50; wt(2, 0, 600); chk("woke_cur", 0, slp);
    repeat (60) @(posedge i_clk); chk("stay_awake", 0, slp);
    chk("no_cal_awake", 0, cal);
    $display("test sleep done");
    final_report;
  end
endmodule // tb
